// *** rtl/alu_pkg.sv ***
// shared types and constants for the rotate, subtract and skip datapath
package alu_pkg;

  // ==========================================================
  // data widths and arithmetic constants
  localparam int        DATA_W      = 8;
  localparam int        ADDR_W      = 8;
  localparam logic [7:0] DEC_STEP   = 8'h01;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] REG_W_OFF      = 8'h00;
  localparam logic [7:0] REG_STATUS_OFF = 8'h04;
  localparam logic [7:0] W_RESET        = 8'h00;
  localparam logic [3:0] STATUS_RESET   = 4'h0;
  localparam logic [3:0] STATUS_PAD_W   = 4'h0;

  // ==========================================================
  // status layout: bit 3 wrap, bit 2 zero, bit 1 half carry, bit 0 carry
  typedef struct packed {
    logic signed_wrap_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } flag_type;

  // ==========================================================
  // instruction codes
  typedef enum logic [2:0] {
    OP_ROTATE_RIGHT_THRU_FLAG_TO_W = 3'h0,
    OP_SUBTRACT_WITH_BORROW        = 3'h1,
    OP_SUBTRACT_BORROW_TO_MEMORY   = 3'h2,
    OP_DECREMENT_SKIP_IF_ZERO      = 3'h3,
    OP_DECREMENT_SKIP_ZERO_TO_W    = 3'h4
  } op_type;

  typedef struct packed {
    logic       valid;
    op_type     op;
    logic [7:0] operand;
  } op_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mem_wr_type;

  // ==========================================================
  // sequencer states, gray along run -> dummy -> run
  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_DUMMY = 1'b1
  } seq_state_type;

endpackage

// *** rtl/sub_borrow_unit.sv ***
// subtract-with-borrow arithmetic and its flag results
`timescale 1ns/1ps
module sub_borrow_unit
  import alu_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  output logic      [7:0] difference,
  output flag_type        flags_out
);

  logic [8:0] full_diff;
  logic [4:0] low_diff;
  logic       borrow_in;

  // ==========================================================
  // carry set means no borrow, so the inverted carry is subtracted
  always_comb begin
    borrow_in  = ~carry_in;
    full_diff  = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    low_diff   = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    difference = full_diff[7:0];
    flags_out.carry_flag       = ~full_diff[8];
    flags_out.half_carry_flag  = ~low_diff[4];
    flags_out.zero_flag        = (full_diff[7:0] == ZERO_BYTE);
    flags_out.signed_wrap_flag = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_diff[7]);
  end

endmodule

// *** rtl/rotate_subtract_skip_alu.sv ***
// datapath for rotate, subtract-with-borrow and decrement-skip instructions
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - rotate puts operand bits 7..1 in w bits 6..0, old carry in w bit 7.
// - rotate copies operand bit 0 into carry; other flags stay.
// - rotate never writes data memory; result goes to w only.
// - subtract computes w minus operand minus inverted carry into w.
// - both subtract forms clear carry on negative, set it otherwise.
// - memory subtract form writes the same result to memory, not w.
// - decrement-skip writes operand minus one to memory, skips on zero.
// - a skip inserts one dummy cycle, making the instruction two cycles.
// - decrement-skip to w puts operand minus one in w, skips on zero.
module rotate_subtract_skip_alu
  import alu_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire op_req_type req,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output mem_wr_type      mem_wr,
  output logic            skip,
  output logic            dummy_cycle,
  output logic            ready,
  output logic      [7:0] w_value,
  output flag_type        flags
);

  // ==========================================================
  // state
  logic          [7:0] w_reg;
  flag_type            flags_reg;
  mem_wr_type          mem_wr_reg;
  logic                skip_reg;
  logic                dummy_reg;
  logic                ready_reg;
  logic          [7:0] rdata_reg;
  seq_state_type       state_reg;
  seq_state_type       state_next;

  logic          [7:0] sub_diff;
  flag_type            sub_flags;
  logic          [7:0] dec_value;
  logic          [7:0] rot_value;
  logic                accept;
  logic                take_skip;

  // ==========================================================
  // decode helpers
  function automatic logic is_sub(input op_type op);
    is_sub = (op == OP_SUBTRACT_WITH_BORROW) || (op == OP_SUBTRACT_BORROW_TO_MEMORY);
  endfunction

  function automatic logic is_dec(input op_type op);
    is_dec = (op == OP_DECREMENT_SKIP_IF_ZERO) || (op == OP_DECREMENT_SKIP_ZERO_TO_W);
  endfunction

  // ==========================================================
  // datapath
  sub_borrow_unit u_sub (
    .minuend    (w_reg),
    .subtrahend (req.operand),
    .carry_in   (flags_reg.carry_flag),
    .difference (sub_diff),
    .flags_out  (sub_flags)
  );

  assign rot_value = {flags_reg.carry_flag, req.operand[7:1]};
  assign dec_value = req.operand - DEC_STEP;
  // requests are taken only while not in the dummy slot
  assign accept    = req.valid && ready_reg;
  assign take_skip = accept && is_dec(req.op) && (dec_value == ZERO_BYTE);

  // ==========================================================
  // working register; an instruction beats a bus write in the same cycle
  // the losing bus write is dropped, not queued, so software must write again
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_reg <= W_RESET;
    end else if (accept) begin
      case (req.op)
        OP_ROTATE_RIGHT_THRU_FLAG_TO_W: begin
          w_reg <= rot_value;
        end
        OP_SUBTRACT_WITH_BORROW: begin
          w_reg <= sub_diff;
        end
        OP_DECREMENT_SKIP_ZERO_TO_W: begin
          w_reg <= dec_value;
        end
        default: begin
          w_reg <= w_reg;
        end
      endcase
    end else if (reg_wr && (reg_addr == REG_W_OFF)) begin
      w_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= STATUS_RESET;
    end else if (accept) begin
      if (req.op == OP_ROTATE_RIGHT_THRU_FLAG_TO_W) begin
        flags_reg.carry_flag <= req.operand[0];
      end else if (is_sub(req.op)) begin
        flags_reg <= sub_flags;
      end
      // decrement-skips fall through and keep every flag
    end else if (reg_wr && (reg_addr == REG_STATUS_OFF)) begin
      flags_reg <= reg_wdata[3:0];
    end
  end

  // ==========================================================
  // data memory write port, one-cycle pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_wr_reg <= '0;
    end else if (accept && (req.op == OP_SUBTRACT_BORROW_TO_MEMORY)) begin
      mem_wr_reg <= '{valid: 1'b1, data: sub_diff};
    end else if (accept && (req.op == OP_DECREMENT_SKIP_IF_ZERO)) begin
      mem_wr_reg <= '{valid: 1'b1, data: dec_value};
    end else begin
      // rotate and the to-w forms leave memory alone
      mem_wr_reg <= '{valid: 1'b0, data: mem_wr_reg.data};
    end
  end

  // ==========================================================
  // skip sequencer: one dummy slot while the next fetch is discarded
  always_comb begin
    case (state_reg)
      ST_RUN: begin
        state_next = take_skip ? ST_DUMMY : ST_RUN;
      end
      ST_DUMMY: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ready comes from state_next so the dummy slot shows in the same cycle as skip
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
      ready_reg <= 1'b0;
      dummy_reg <= 1'b0;
      skip_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_RUN);
      dummy_reg <= (state_next == ST_DUMMY);
      skip_reg  <= take_skip;
    end
  end

  // ==========================================================
  // register read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= ZERO_BYTE;
    end else if (reg_rd && (reg_addr == REG_W_OFF)) begin
      rdata_reg <= w_reg;
    end else if (reg_rd && (reg_addr == REG_STATUS_OFF)) begin
      rdata_reg <= {STATUS_PAD_W, flags_reg};
    end else begin
      rdata_reg <= ZERO_BYTE;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign mem_wr      = mem_wr_reg;
  assign skip        = skip_reg;
  assign dummy_cycle = dummy_reg;
  assign ready       = ready_reg;
  assign w_value     = w_reg;
  assign flags       = flags_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic       took_rot;
  logic       took_sub;
  logic       took_sub_mem;
  logic       took_dec_mem;
  logic       took_dec_w;
  logic [8:0] wide_diff;
  assign took_rot     = accept && (req.op == OP_ROTATE_RIGHT_THRU_FLAG_TO_W);
  assign took_sub     = accept && (req.op == OP_SUBTRACT_WITH_BORROW);
  assign took_sub_mem = accept && (req.op == OP_SUBTRACT_BORROW_TO_MEMORY);
  assign took_dec_mem = accept && (req.op == OP_DECREMENT_SKIP_IF_ZERO);
  assign took_dec_w   = accept && (req.op == OP_DECREMENT_SKIP_ZERO_TO_W);
  // sign-extended difference: bits 8 and 7 disagree exactly on a signed wrap
  assign wide_diff    = {w_reg[7], w_reg} - {req.operand[7], req.operand}
                        - {8'h00, !flags_reg.carry_flag};

  a_rotate_w_value: assert property (
    took_rot |=> w_reg == {$past(flags_reg.carry_flag), $past(req.operand[7:1])})
    else $error("rotate result in w wrong");

  a_rotate_carry_only: assert property (
    took_rot |=> (flags_reg.carry_flag == $past(req.operand[0]))
      && $stable(flags_reg.zero_flag) && $stable(flags_reg.half_carry_flag)
      && $stable(flags_reg.signed_wrap_flag))
    else $error("rotate flag update wrong");

  a_rotate_no_mem: assert property (
    took_rot |=> !mem_wr_reg.valid)
    else $error("rotate wrote memory");

  a_mem_write_only: assert property (
    !(took_sub_mem || took_dec_mem) |=> !mem_wr_reg.valid)
    else $error("memory written by wrong instruction");

  a_sub_w_result: assert property (
    took_sub |=> (w_reg == 8'($past(w_reg) - $past(req.operand)
      - {7'h00, !$past(flags_reg.carry_flag)})) && !mem_wr_reg.valid)
    else $error("subtract result in w wrong");

  a_sub_carry_sign: assert property (
    (took_sub || took_sub_mem) |=> flags_reg.carry_flag ==
      ({1'b0, $past(w_reg)} >= ({1'b0, $past(req.operand)}
      + {8'h00, !$past(flags_reg.carry_flag)})))
    else $error("subtract carry wrong");

  a_sub_mem_result: assert property (
    took_sub_mem |=> mem_wr_reg.valid && $stable(w_reg) && (mem_wr_reg.data ==
      8'($past(w_reg) - $past(req.operand) - {7'h00, !$past(flags_reg.carry_flag)})))
    else $error("memory subtract wrong");

  a_dec_mem_skip: assert property (
    took_dec_mem |=> mem_wr_reg.valid && (mem_wr_reg.data == 8'($past(req.operand) - 8'h01))
      && (skip_reg == (mem_wr_reg.data == 8'h00)))
    else $error("decrement to memory wrong");

  a_dec_mem_keeps_w: assert property (
    took_dec_mem |=> $stable(w_reg))
    else $error("decrement to memory changed w");

  a_skip_source: assert property (
    !(took_dec_mem || took_dec_w) |=> !skip_reg)
    else $error("skip without decrement");

  a_skip_two_cycle: assert property (
    skip_reg |-> dummy_reg && !ready_reg ##1 !dummy_reg && ready_reg && !skip_reg)
    else $error("skip dummy slot wrong");

  a_dummy_no_exec: assert property (
    (req.valid && !ready_reg && !reg_wr) |=> $stable(w_reg) && $stable(flags_reg)
      && !mem_wr_reg.valid && !skip_reg)
    else $error("request taken in dummy slot");

  a_rotate_no_dummy: assert property (
    took_rot |=> !dummy_reg && ready_reg)
    else $error("rotate opened a dummy slot");

  a_dec_w_skip: assert property (
    took_dec_w |=> !mem_wr_reg.valid && (w_reg == 8'($past(req.operand) - 8'h01))
      && (skip_reg == (w_reg == 8'h00)))
    else $error("decrement to w wrong");

  a_dec_flags_kept: assert property (
    (took_dec_mem || took_dec_w) |=> $stable(flags_reg))
    else $error("decrement changed flags");

  a_sub_zero_flag: assert property (
    took_sub |=> flags_reg.zero_flag == (w_reg == 8'h00))
    else $error("subtract zero flag wrong");

  a_sub_mem_zero: assert property (
    took_sub_mem |=> flags_reg.zero_flag == (mem_wr_reg.data == ZERO_BYTE))
    else $error("memory subtract zero flag wrong");

  a_sub_half_carry: assert property (
    (took_sub || took_sub_mem) |=> flags_reg.half_carry_flag ==
      ({1'b0, $past(w_reg[3:0])} >= ({1'b0, $past(req.operand[3:0])}
      + {4'h0, !$past(flags_reg.carry_flag)})))
    else $error("subtract half carry wrong");

  a_sub_wrap_flag: assert property (
    (took_sub || took_sub_mem) |=> flags_reg.signed_wrap_flag
      == ($past(wide_diff[8]) ^ $past(wide_diff[7])))
    else $error("subtract wrap flag wrong");

  c_rotate: cover property (took_rot ##1 !mem_wr_reg.valid);
  c_sub_borrow: cover property (took_sub_mem ##1 !flags_reg.carry_flag);
  c_dec_skip: cover property (took_dec_mem ##1 skip_reg ##1 ready_reg);
  c_decw_skip: cover property (took_dec_w ##1 skip_reg);
  c_dummy_wait: cover property (req.valid && dummy_reg ##1 took_rot);

endmodule

// *** dv/core_model.sv ***
// core sequencer and data memory model facing the datapath
`timescale 1ns/1ps
module core_model
  import alu_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       issue_valid,
  input  wire op_type     issue_op,
  input  wire logic [1:0] issue_addr,
  input  wire mem_wr_type mem_wr,
  output op_req_type      req
);
  logic [7:0] mem [4]     = '{8'h80, 8'h07, 8'h01, 8'h01};
  logic [1:0] wr_addr_reg = 2'h0;
  // ==========================================================
  // operand read from memory while the instruction is issued
  assign req = '{valid: issue_valid, op: issue_op, operand: mem[issue_addr]};
  // write-back lands a cycle after the take, so the address is kept
  always @(posedge mclk) begin
    if (issue_valid) begin
      wr_addr_reg <= issue_addr;
    end
    if (mem_wr.valid) begin
      mem[wr_addr_reg] <= mem_wr.data;
    end
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/1ps
module testbench
  import alu_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic       iv   = 1'b0;
  op_type     iop  = OP_ROTATE_RIGHT_THRU_FLAG_TO_W;
  logic [1:0] ia   = 2'h0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  op_req_type req;
  mem_wr_type mem_wr;
  logic       skip;
  logic       dummy_cycle;
  logic       ready;
  logic [7:0] w_value;
  flag_type   flags;
  int         err_count   = 0;
  int         check_count = 0;
  int         cycles      = 0;
  // ==========================================================
  // clock, design and partner
  initial begin
    forever #20 mclk = ~mclk;
  end
  rotate_subtract_skip_alu i_rotate_subtract_skip_alu (.mclk(mclk), .rst(rst), .req(req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_wr(mem_wr), .skip(skip), .dummy_cycle(dummy_cycle),
    .ready(ready), .w_value(w_value), .flags(flags));
  core_model i_core_model (.mclk(mclk), .issue_valid(iv), .issue_op(iop), .issue_addr(ia),
    .mem_wr(mem_wr), .req(req));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // issue one instruction; returns 1 ns into the answer cycle
  task automatic exec(input op_type op, input logic [1:0] a);
    @(posedge mclk);
    iv <= 1'b1;
    iop <= op;
    ia <= a;
    @(posedge mclk);
    iv <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    wr(REG_W_OFF, 8'h5a);
    wr(REG_STATUS_OFF, 8'hff);
    rd(REG_W_OFF, 8'h5a);
    rd(8'h33, 8'h00);
    rd(REG_STATUS_OFF, 8'h0f);
    @(posedge mclk);
    #1 chk(reg_rdata, 8'h00);
  endtask
  task automatic t_rotate;
    wr(REG_STATUS_OFF, 8'h0d);
    exec(OP_ROTATE_RIGHT_THRU_FLAG_TO_W, 2'h0);
    chk(w_value, 8'hc0);
    chk({4'h0, flags}, 8'h0c);
    chk({7'h00, mem_wr.valid}, 8'h00);
  endtask
  task automatic t_subtract;
    wr(REG_W_OFF, 8'h05);
    wr(REG_STATUS_OFF, 8'h01);
    exec(OP_SUBTRACT_WITH_BORROW, 2'h1);
    chk(w_value, 8'hfe);
    chk({4'h0, flags}, 8'h00);
    exec(OP_SUBTRACT_BORROW_TO_MEMORY, 2'h1);
    chk({mem_wr.valid, 7'h00}, 8'h80);
    chk(mem_wr.data, 8'hf6);
    chk(w_value, 8'hfe);
    chk({4'h0, flags}, 8'h03);
  endtask
  task automatic t_skip_mem;
    wr(REG_STATUS_OFF, 8'h0a);
    exec(OP_DECREMENT_SKIP_IF_ZERO, 2'h2);
    chk({mem_wr.valid, skip, dummy_cycle, ready}, 8'h0e);
    chk(mem_wr.data, 8'h00);
    chk({4'h0, flags}, 8'h0a);
    exec(OP_DECREMENT_SKIP_IF_ZERO, 2'h2);
    chk({mem_wr.valid, skip, dummy_cycle, ready}, 8'h09);
    chk(mem_wr.data, 8'hff);
  endtask
  task automatic t_skip_w;
    @(posedge mclk);
    iv <= 1'b1;
    iop <= OP_DECREMENT_SKIP_ZERO_TO_W;
    ia <= 2'h3;
    @(posedge mclk);
    iop <= OP_ROTATE_RIGHT_THRU_FLAG_TO_W;
    ia <= 2'h0;
    #1 chk(w_value, 8'h00);
    chk({mem_wr.valid, skip, dummy_cycle, ready}, 8'h06);
    chk({4'h0, flags}, 8'h0a);
    // the rotate is held through the dummy slot and must run only once, after it
    @(posedge mclk);
    #1 chk(w_value, 8'h00);
    @(posedge mclk);
    iv <= 1'b0;
    #1 chk(w_value, 8'h40);
    wr(REG_W_OFF, 8'h80);
    wr(REG_STATUS_OFF, 8'h01);
    exec(OP_SUBTRACT_WITH_BORROW, 2'h3);
    chk(w_value, 8'h7f);
    chk({4'h0, flags}, 8'h09);
  endtask
  task automatic t_memory;
    @(posedge mclk);
    chk(i_core_model.mem[3], 8'h01);
    chk(i_core_model.mem[2], 8'hff);
    chk(i_core_model.mem[1], 8'hf6);
    chk(i_core_model.mem[0], 8'h80);
  endtask
  task automatic t_reset;
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1 chk(w_value, 8'h00);
    chk({skip, dummy_cycle, mem_wr.valid, ready, flags}, 8'h00);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk({7'h00, ready}, 8'h01);
    exec(OP_ROTATE_RIGHT_THRU_FLAG_TO_W, 2'h0);
    chk(w_value, 8'h40);
    chk({4'h0, flags}, 8'h00);
  endtask
  // ==========================================================
  // verdict, main sequence and hang guard
  task automatic summarize;
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_rotate();
    t_subtract();
    t_skip_mem();
    t_skip_w();
    t_memory();
    t_reset();
    summarize();
  end
endmodule
